// *** hw/ubhp_pkg.sv ***
// Package with register map, field positions and constants of the host port
package ubhp_pkg;
  // Register byte addresses on the host port
  localparam logic [7:0] REG_BUF_LEN = 8'h1c;
  localparam logic [7:0] REG_DATA_PORT = 8'h20;
  localparam logic [7:0] REG_CTRL_FUNC = 8'h28;
  localparam logic [7:0] REG_EP_INDEX = 8'h2c;
  localparam logic [7:0] REG_DMA_CMD = 8'h30;
  localparam logic [7:0] REG_DMA_COUNT = 8'h34;
  localparam logic [7:0] REG_DMA_CFG = 8'h38;
  localparam logic [7:0] REG_DMA_HW = 8'h3c;
  localparam logic [7:0] REG_DMA_REASON = 8'h50;
  localparam logic [7:0] REG_DMA_EP = 8'h58;
  localparam logic [7:0] REG_EP_ENABLE = 8'h60;
  localparam logic [7:0] REG_PORT_STAT = 8'h64;
  // Field positions
  localparam int CFG_WIDE_BIT = 0;
  localparam int CFG_HANDSHAKE_BIT = 1;
  localparam int CFG_ATA_BIT = 8;
  localparam int HW_MASTER_BIT = 0;
  localparam int CTRL_CLR_BUF_BIT = 0;
  localparam int CMD_DIR_OUT_BIT = 7;
  localparam int REASON_DONE_BIT = 0;
  localparam int REASON_ERR_BIT = 1;
  // DMA command kinds in command bits 2:0
  localparam logic [2:0] KIND_GDMA = 3'h1;
  localparam logic [2:0] KIND_PIO = 3'h2;
  localparam logic [2:0] KIND_MDMA = 3'h3;
  localparam logic [2:0] KIND_UDMA = 3'h4;
  // Buffer RAM: 8 kbytes as 4096 words, 256 words per endpoint
  localparam int RAM_WORDS = 4096;
  localparam int NUM_EP = 16;
  // Reset values; the two control endpoints are always enabled
  localparam logic [15:0] EP_ENABLE_RST = 16'h0003;
  localparam logic [15:0] DMA_CFG_RST = 16'h0001;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  typedef enum {DMA_IDLE, DMA_SLAVE, DMA_M_ON, DMA_M_OFF} ubhp_dma_t;
endpackage : ubhp_pkg

// *** hw/ubhp_port.sv ***
// Host bus port with register file, buffer RAM and DMA engine
`timescale 1ns/1ps
module ubhp_port
  import ubhp_pkg::*;
(
  input wire logic CORE_CLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic CLK_EN_IN,
  input wire logic BUS_CONFIG_SELECT_IN,
  input wire logic STROBE_STYLE_SELECT_IN,
  input wire logic ADDRESS_PHASE_SELECT_IN,
  input wire logic HOST_SEL_N_IN,
  input wire logic ALE_IN,
  input wire logic ADDRESS_DATA_INDICATOR_IN,
  input wire logic RD_N_IN,
  input wire logic WR_N_IN,
  input wire logic RW_IN,
  input wire logic DATA_STROBE_N_IN,
  input wire logic [7:0] AD_IN,
  output logic [7:0] AD_OUT,
  output logic AD_OE_OUT,
  input wire logic [15:0] DATA_IN,
  output logic [15:0] DATA_OUT,
  output logic DATA_OE_OUT,
  input wire logic DMA_READ_STROBE_IN,
  input wire logic DMA_WRITE_STROBE_IN,
  input wire logic DMA_ACKNOWLEDGE_IN,
  output logic DMA_REQUEST_OUT,
  output logic DMA_READ_STROBE_OUT,
  output logic DMA_WRITE_STROBE_OUT
);

  function automatic logic [15:0] ubhp_merge(input logic [15:0] o,
    input logic [15:0] n, input logic [1:0] be);
    ubhp_merge = {be[1] ? n[15:8] : o[15:8], be[0] ? n[7:0] : o[7:0]};
  endfunction : ubhp_merge

  logic cfg_taken, cfg_sep, cfg_rdwr, cfg_adi;
  logic rd_act, wr_act, adi_addr, acc_rd, acc_wr;
  logic rd_q, wr_q, commit, rd_start;
  logic [7:0] addr_latch, eff_addr, h_addr, c_reg, r_addr;
  logic [15:0] h_data, dp_lo, rdata;
  logic [1:0] c_be;
  logic [3:0] ep_index, dma_ep;
  logic [15:0] ep_enable, buf_len, dma_cfg, dma_count, buf_valid;
  logic [7:0] dma_hw, dma_cmd;
  logic [1:0] reason;
  logic [15:0] ram [RAM_WORDS];
  logic [11:0] host_ptr, dma_ptr;
  logic host_wr_go, host_rd_adv;
  ubhp_dma_t dma_state;
  logic dma_out, dma_byte, dma_master, dma_hs, beat, dma_done;
  logic cmd_go, cmd_ok, master_eff, rs_q, ws_q, ack_q;
  logic [15:0] step;

  // Straps sampled once at first enabled cycle after reset
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (SYS_RST_IN)
    begin
      cfg_taken <= 1'b0;
      cfg_sep <= 1'b0;
      cfg_rdwr <= 1'b0;
      cfg_adi <= 1'b1;
    end
    else if (CLK_EN_IN && !cfg_taken)
    begin
      cfg_taken <= 1'b1;
      cfg_sep <= BUS_CONFIG_SELECT_IN;
      cfg_rdwr <= STROBE_STYLE_SELECT_IN;
      cfg_adi <= ADDRESS_PHASE_SELECT_IN;
    end
  end

  always_comb
  begin
    if (cfg_rdwr)
    begin
      rd_act = !RD_N_IN;
      wr_act = !WR_N_IN;
    end
    else
    begin
      rd_act = !DATA_STROBE_N_IN && RW_IN;
      wr_act = !DATA_STROBE_N_IN && !RW_IN;
    end
    // Select only gates the multiplexed bus
    rd_act = rd_act && cfg_taken && (cfg_sep || !HOST_SEL_N_IN);
    wr_act = wr_act && cfg_taken && (cfg_sep || !HOST_SEL_N_IN);
    // Indicator has no meaning on the separate bus
    adi_addr = !cfg_sep && cfg_adi && !ADDRESS_DATA_INDICATOR_IN;
    acc_rd = rd_act && !adi_addr;
    acc_wr = wr_act && !adi_addr;
    eff_addr = cfg_sep ? AD_IN : addr_latch;
  end

  always_ff @(posedge CORE_CLK_IN)
  begin
    if (SYS_RST_IN)
      addr_latch <= 8'h00;
    else if (CLK_EN_IN && !cfg_sep)
    begin
      if (!cfg_adi && ALE_IN)
        addr_latch <= AD_IN;
      else if (cfg_adi && wr_act && adi_addr)
        addr_latch <= AD_IN;
    end
  end

  // Writes commit on the trailing strobe edge with held address and data
  assign commit = wr_q && !acc_wr;
  assign rd_start = acc_rd && !rd_q;
  assign c_reg = cfg_sep ? h_addr : {h_addr[7:1], 1'b0};
  assign c_be = cfg_sep ? 2'b11 : (h_addr[0] ? 2'b10 : 2'b01);
  assign r_addr = cfg_sep ? eff_addr : {eff_addr[7:1], 1'b0};
  assign host_wr_go = commit && c_reg == REG_DATA_PORT &&
    ep_enable[ep_index] && (cfg_sep || h_addr[0]);
  assign host_rd_adv = rd_q && !acc_rd && h_addr == (cfg_sep ?
    REG_DATA_PORT : {REG_DATA_PORT[7:1], 1'b1});
  assign cmd_go = commit && c_reg == REG_DMA_CMD && c_be[0];

  always_ff @(posedge CORE_CLK_IN)
  begin
    if (SYS_RST_IN)
    begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      h_addr <= 8'h00;
      h_data <= WORD_ZERO;
    end
    else if (CLK_EN_IN)
    begin
      wr_q <= acc_wr;
      rd_q <= acc_rd;
      if (acc_wr || rd_start)
        h_addr <= eff_addr;
      if (acc_wr)
        h_data <= cfg_sep ? DATA_IN : {AD_IN, AD_IN};
    end
  end

  // Read mux over the register file
  always_comb
  begin
    case (r_addr)
      REG_BUF_LEN: rdata = buf_len;
      REG_DATA_PORT: rdata = ram[host_ptr];
      REG_CTRL_FUNC: rdata = buf_valid;
      REG_EP_INDEX: rdata = {12'h000, ep_index};
      REG_DMA_CMD: rdata = {8'h00, dma_cmd};
      REG_DMA_COUNT: rdata = dma_count;
      REG_DMA_CFG: rdata = dma_cfg;
      REG_DMA_HW: rdata = {8'h00, dma_hw};
      REG_DMA_REASON: rdata = {14'h0000, reason};
      REG_DMA_EP: rdata = {12'h000, dma_ep};
      REG_EP_ENABLE: rdata = ep_enable;
      REG_PORT_STAT: rdata = {11'h000, dma_state != DMA_IDLE, cfg_taken,
        cfg_adi, cfg_rdwr, cfg_sep};
      default: rdata = WORD_ZERO;
    endcase
  end

  // Host pin drivers; DMA owns the data bus unless a host read holds it
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (SYS_RST_IN)
    begin
      AD_OUT <= 8'h00;
      AD_OE_OUT <= 1'b0;
      DATA_OUT <= WORD_ZERO;
      DATA_OE_OUT <= 1'b0;
    end
    else if (CLK_EN_IN)
    begin
      AD_OE_OUT <= acc_rd && !cfg_sep;
      if (rd_start && !cfg_sep)
        AD_OUT <= eff_addr[0] ? rdata[15:8] : rdata[7:0];
      if (acc_rd && cfg_sep)
      begin
        DATA_OE_OUT <= 1'b1;
        if (rd_start)
          DATA_OUT <= rdata;
      end
      else
      begin
        DATA_OE_OUT <= dma_out && (dma_state == DMA_M_ON ||
          (dma_state == DMA_SLAVE && (dma_hs ? DMA_ACKNOWLEDGE_IN :
          DMA_READ_STROBE_IN)));
        DATA_OUT <= dma_byte ? {8'h00, ram[dma_ptr][15:8]} :
          (dma_cfg[CFG_WIDE_BIT] ? ram[dma_ptr] :
          {8'h00, ram[dma_ptr][7:0]});
      end
    end
  end

  // Register file written by the host
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (SYS_RST_IN)
    begin
      ep_index <= 4'h0;
      dma_ep <= 4'h0;
      ep_enable <= EP_ENABLE_RST;
      buf_len <= WORD_ZERO;
      dma_cfg <= DMA_CFG_RST;
      dma_hw <= 8'h00;
      dma_cmd <= 8'h00;
      dp_lo <= WORD_ZERO;
    end
    else if (CLK_EN_IN && commit)
    begin
      case (c_reg)
        REG_EP_INDEX: if (c_be[0]) ep_index <= h_data[3:0];
        REG_DMA_EP: if (c_be[0]) dma_ep <= h_data[3:0];
        REG_EP_ENABLE: ep_enable <= ubhp_merge(ep_enable, h_data, c_be) |
          EP_ENABLE_RST;
        REG_BUF_LEN: buf_len <= ubhp_merge(buf_len, h_data, c_be);
        REG_DMA_CFG: dma_cfg <= ubhp_merge(dma_cfg, h_data, c_be);
        REG_DMA_HW: if (c_be[0]) dma_hw <= h_data[7:0];
        REG_DMA_CMD: if (c_be[0]) dma_cmd <= h_data[7:0];
        REG_DATA_PORT: if (c_be == 2'b01) dp_lo <= h_data;
        default: dp_lo <= dp_lo;
      endcase
    end
  end

  // Legality of the command against role and interface kind
  assign master_eff = dma_hw[HW_MASTER_BIT] && !cfg_sep;
  always_comb
  begin
    if (dma_cfg[CFG_ATA_BIT])
      cmd_ok = h_data[2:0] == KIND_PIO || h_data[2:0] == KIND_MDMA ||
        h_data[2:0] == KIND_UDMA;
    else
      cmd_ok = (h_data[2:0] == KIND_GDMA && !master_eff) ||
        (h_data[2:0] == KIND_MDMA && master_eff);
    cmd_ok = cmd_ok && dma_count != WORD_ZERO && dma_state == DMA_IDLE;
  end

  assign step = dma_cfg[CFG_WIDE_BIT] ? 16'h0002 : 16'h0001;
  // Slave beats on external strobe or acknowledge rising edges
  assign beat = (dma_state == DMA_SLAVE && (dma_hs ? (DMA_ACKNOWLEDGE_IN &&
    !ack_q) : (dma_out ? (DMA_READ_STROBE_IN && !rs_q) :
    (DMA_WRITE_STROBE_IN && !ws_q)))) || dma_state == DMA_M_ON;
  assign dma_done = beat && dma_count <= step;

  always_ff @(posedge CORE_CLK_IN)
  begin
    if (SYS_RST_IN)
    begin
      dma_state <= DMA_IDLE;
      dma_out <= 1'b0;
      dma_master <= 1'b0;
      dma_hs <= 1'b0;
      dma_byte <= 1'b0;
      dma_count <= WORD_ZERO;
      rs_q <= 1'b0;
      ws_q <= 1'b0;
      ack_q <= 1'b0;
      DMA_REQUEST_OUT <= 1'b0;
      DMA_READ_STROBE_OUT <= 1'b0;
      DMA_WRITE_STROBE_OUT <= 1'b0;
    end
    else if (CLK_EN_IN)
    begin
      rs_q <= DMA_READ_STROBE_IN;
      ws_q <= DMA_WRITE_STROBE_IN;
      ack_q <= DMA_ACKNOWLEDGE_IN;
      if (commit && c_reg == REG_DMA_COUNT && dma_state == DMA_IDLE)
        dma_count <= ubhp_merge(dma_count, h_data, c_be);
      else if (beat)
        dma_count <= dma_done ? WORD_ZERO : dma_count - step;
      if (beat && !dma_cfg[CFG_WIDE_BIT])
        dma_byte <= !dma_byte;
      case (dma_state)
        DMA_IDLE:
          if (cmd_go && cmd_ok)
          begin
            dma_out <= h_data[CMD_DIR_OUT_BIT];
            dma_master <= master_eff;
            dma_hs <= dma_cfg[CFG_HANDSHAKE_BIT];
            dma_byte <= 1'b0;
            dma_state <= master_eff ? DMA_M_OFF : DMA_SLAVE;
          end
        DMA_SLAVE:
          if (dma_done)
            dma_state <= DMA_IDLE;
        DMA_M_OFF:
          if (!dma_hs || DMA_ACKNOWLEDGE_IN)
            dma_state <= DMA_M_ON;
        DMA_M_ON:
          dma_state <= dma_done ? DMA_IDLE : DMA_M_OFF;
        default:
          dma_state <= DMA_IDLE;
      endcase
      DMA_REQUEST_OUT <= dma_hs && !dma_done && (dma_state == DMA_SLAVE ||
        dma_state == DMA_M_OFF || dma_state == DMA_M_ON);
      DMA_WRITE_STROBE_OUT <= dma_state == DMA_M_OFF && dma_out &&
        (!dma_hs || DMA_ACKNOWLEDGE_IN);
      DMA_READ_STROBE_OUT <= dma_state == DMA_M_OFF && !dma_out &&
        (!dma_hs || DMA_ACKNOWLEDGE_IN);
    end
  end

  // Reason flags: hardware set wins over software write-one clear
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (SYS_RST_IN)
      reason <= 2'b00;
    else if (CLK_EN_IN)
    begin
      if (commit && c_reg == REG_DMA_REASON && c_be[0])
        reason <= reason & ~h_data[1:0];
      if (dma_done)
        reason[REASON_DONE_BIT] <= 1'b1;
      if (cmd_go && !cmd_ok)
        reason[REASON_ERR_BIT] <= 1'b1;
    end
  end

  // Validation by length write; release by clear or DMA completion
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (SYS_RST_IN)
      buf_valid <= WORD_ZERO;
    else if (CLK_EN_IN)
    begin
      if (commit && c_reg == REG_CTRL_FUNC && c_be[0] &&
        h_data[CTRL_CLR_BUF_BIT])
        buf_valid[ep_index] <= 1'b0;
      if (dma_done)
        buf_valid[dma_ep] <= 1'b0;
      if (commit && c_reg == REG_BUF_LEN && ep_enable[ep_index])
        buf_valid[ep_index] <= 1'b1;
    end
  end

  // Shared buffer RAM; each endpoint owns a fixed 256-word slice
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (SYS_RST_IN)
    begin
      host_ptr <= 12'h000;
      dma_ptr <= 12'h000;
    end
    else if (CLK_EN_IN)
    begin
      if (commit && c_reg == REG_EP_INDEX)
        host_ptr <= {h_data[3:0], 8'h00};
      else if (host_wr_go || host_rd_adv)
        host_ptr <= {host_ptr[11:8], host_ptr[7:0] + 8'h01};
      if (commit && c_reg == REG_DMA_EP)
        dma_ptr <= {h_data[3:0], 8'h00};
      else if (beat && (dma_cfg[CFG_WIDE_BIT] || dma_byte))
        dma_ptr <= {dma_ptr[11:8], dma_ptr[7:0] + 8'h01};
      if (host_wr_go)
        ram[host_ptr] <= cfg_sep ? h_data : {h_data[15:8], dp_lo[7:0]};
      if (beat && !dma_out)
        ram[dma_ptr] <= dma_cfg[CFG_WIDE_BIT] ? DATA_IN : ubhp_merge(
          ram[dma_ptr], {DATA_IN[7:0], DATA_IN[7:0]},
          dma_byte ? 2'b10 : 2'b01);
    end
  end

  default clocking @(posedge CORE_CLK_IN); endclocking
  default disable iff (SYS_RST_IN || !CLK_EN_IN);

  // Last reset edge is excluded: its attempt would check before the take
  property p_cfg_take;
    !SYS_RST_IN && !cfg_taken
      |=> cfg_taken && cfg_sep == $past(BUS_CONFIG_SELECT_IN);
  endproperty
  a_cfg_take: assert property (p_cfg_take) else $error("strap miss");
  property p_cfg_hold;
    cfg_taken |=> $stable(cfg_sep) && $stable(cfg_rdwr) && $stable(cfg_adi);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("strap moved");
  property p_sep_data;
    cfg_sep && acc_rd ##1 acc_rd |-> DATA_OE_OUT && !AD_OE_OUT;
  endproperty
  a_sep_data: assert property (p_sep_data) else $error("sep read");
  property p_mux_ad;
    !cfg_sep && acc_rd |=> AD_OE_OUT;
  endproperty
  a_mux_ad: assert property (p_mux_ad) else $error("mux read");
  property p_rdwr;
    cfg_taken && cfg_rdwr && !RD_N_IN && cfg_sep |-> acc_rd;
  endproperty
  a_rdwr: assert property (p_rdwr) else $error("rd strobe");
  property p_ds;
    cfg_taken && !cfg_rdwr && !DATA_STROBE_N_IN && !RW_IN && cfg_sep
      |-> acc_wr && !acc_rd;
  endproperty
  a_ds: assert property (p_ds) else $error("data strobe");
  property p_ale;
    !cfg_sep && !cfg_adi && ALE_IN |=> addr_latch == $past(AD_IN);
  endproperty
  a_ale: assert property (p_ale) else $error("ale latch");
  property p_adi;
    !cfg_sep && cfg_adi && !ADDRESS_DATA_INDICATOR_IN |-> !acc_wr && !acc_rd;
  endproperty
  a_adi: assert property (p_adi) else $error("adi phase");
  property p_sep_slave;
    cfg_sep |-> !dma_master && dma_state != DMA_M_ON &&
      dma_state != DMA_M_OFF;
  endproperty
  a_sep_slave: assert property (p_sep_slave) else $error("master");
  property p_bad_cmd;
    cmd_go && !cmd_ok && dma_state == DMA_IDLE |=> dma_state == DMA_IDLE
      && reason[REASON_ERR_BIT];
  endproperty
  a_bad_cmd: assert property (p_bad_cmd) else $error("bad cmd");
  property p_release;
    dma_done |=> !buf_valid[$past(dma_ep)] && dma_state == DMA_IDLE;
  endproperty
  a_release: assert property (p_release) else $error("release");
  property p_narrow;
    beat && !dma_cfg[CFG_WIDE_BIT] && !dma_done
      |=> dma_count == $past(dma_count) - 16'h0001;
  endproperty
  a_narrow: assert property (p_narrow) else $error("width");

  c_slave_done: cover property (dma_state == DMA_SLAVE && dma_done);
  c_master_done: cover property (dma_state == DMA_M_ON && dma_done);
  c_mux_write: cover property (!cfg_sep && host_wr_go);
  c_adi_addr: cover property (cfg_adi && wr_act && adi_addr);

endmodule : ubhp_port

// *** bench/ubhp_dma_dev.sv ***
// External DMA device model facing the host port
`timescale 1ns/1ps
module ubhp_dma_dev
(
  input wire logic clk_in,
  input wire logic start_in,
  input wire logic [7:0] beats_in,
  input wire logic hs_in,
  input wire logic req_in,
  input wire logic m_rd_in,
  input wire logic m_wr_in,
  output logic wr_strobe_out,
  output logic ack_out,
  output logic busy_out,
  output logic [15:0] data_out,
  output int pulses_out
);
  initial
  begin
    wr_strobe_out = 1'b0;
    ack_out = 1'b0;
    busy_out = 1'b0;
    data_out = 16'h5a5a;
    pulses_out = 0;
  end
  always @(posedge clk_in)
    if (m_rd_in || m_wr_in)
      pulses_out <= pulses_out + 1;
  always
  begin
    @(posedge start_in);
    busy_out <= 1'b1;
    for (int i = 0; i < beats_in; i++)
    begin
      @(posedge clk_in);
      data_out <= 16'hc300 + 16'(i);
      while (hs_in && !req_in)
        @(posedge clk_in);
      @(posedge clk_in);
      if (hs_in)
        ack_out <= 1'b1;
      else
        wr_strobe_out <= 1'b1;
      @(posedge clk_in);
      ack_out <= 1'b0;
      wr_strobe_out <= 1'b0;
      // Released bus must not keep its last value
      @(posedge clk_in);
      data_out <= ~data_out;
    end
    busy_out <= 1'b0;
  end
endmodule : ubhp_dma_dev

// *** bench/ubhp_port_tb_top.sv ***
// Self-checking bench for the host bus port
`timescale 1ns/1ps
module ubhp_port_tb_top;
  import ubhp_pkg::*;
  logic clk, rst, p_sep, p_style, p_phase, sep, style, phase;
  logic host_sel_n, ale, ind, rd_n, wr_n, rw, ds_n, start, hs;
  logic [7:0] host_ad, ad_out, beats;
  logic [15:0] host_data, data_out, dma_data, q;
  logic ad_oe, data_oe, req, mrd, mwr, dwr, ack, dma_busy;
  wire logic [7:0] ad_bus;
  wire logic [15:0] data_bus;
  int pulses, base, n_errors, compares;
  logic [2:0] bad_kinds [3] = '{KIND_PIO, KIND_UDMA, 3'h7};
  assign ad_bus = ad_oe ? ad_out : host_ad;
  assign data_bus = data_oe ? data_out : (dma_busy ? dma_data : host_data);
  ubhp_port u_ubhp_port (.CORE_CLK_IN(clk), .SYS_RST_IN(rst),
    .CLK_EN_IN(1'b1), .BUS_CONFIG_SELECT_IN(p_sep),
    .STROBE_STYLE_SELECT_IN(p_style), .ADDRESS_PHASE_SELECT_IN(p_phase),
    .HOST_SEL_N_IN(host_sel_n), .ALE_IN(ale),
    .ADDRESS_DATA_INDICATOR_IN(ind), .RD_N_IN(rd_n), .WR_N_IN(wr_n),
    .RW_IN(rw), .DATA_STROBE_N_IN(ds_n), .AD_IN(ad_bus), .AD_OUT(ad_out),
    .AD_OE_OUT(ad_oe), .DATA_IN(data_bus), .DATA_OUT(data_out),
    .DATA_OE_OUT(data_oe), .DMA_READ_STROBE_IN(1'b0),
    .DMA_WRITE_STROBE_IN(dwr), .DMA_ACKNOWLEDGE_IN(ack),
    .DMA_REQUEST_OUT(req), .DMA_READ_STROBE_OUT(mrd),
    .DMA_WRITE_STROBE_OUT(mwr));
  ubhp_dma_dev u_ubhp_dma_dev (.clk_in(clk), .start_in(start),
    .beats_in(beats), .hs_in(hs), .req_in(req), .m_rd_in(mrd),
    .m_wr_in(mwr), .wr_strobe_out(dwr), .ack_out(ack),
    .busy_out(dma_busy), .data_out(dma_data), .pulses_out(pulses));
  initial
  begin
    clk = 1'b0;
    forever
      #50 clk = ~clk;
  end
  task automatic tally_and_finish();
    $display("TB: errors=%0d compares=%0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic boot(input logic s, input logic st, input logic ph);
    @(posedge clk);
    {sep, style, phase} <= {s, st, ph};
    {p_sep, p_style, p_phase} <= {s, st, ph};
    host_sel_n <= s;
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : boot
  task automatic strobe(input logic wr, input logic [15:0] d,
                        output logic [15:0] r);
    @(posedge clk);
    host_data <= wr ? d : ~host_data;
    if (!sep)
      host_ad <= wr ? d[7:0] : ~host_ad;
    if (style)
      {wr_n, rd_n} <= {!wr, wr};
    else
      {rw, ds_n} <= {!wr, 1'b0};
    repeat (3) @(posedge clk);
    #10 r = sep ? data_out : {8'h00, ad_out};
    @(posedge clk);
    {rd_n, wr_n, ds_n} <= 3'h7;
    repeat (2) @(posedge clk);
  endtask : strobe
  task automatic aphase(input logic [7:0] a);
    logic [15:0] junk;
    @(posedge clk);
    host_ad <= a;
    if (!phase)
    begin
      ale <= 1'b1;
      @(posedge clk);
      ale <= 1'b0;
    end
    else
    begin
      ind <= 1'b0;
      strobe(1'b1, {8'h00, a}, junk);
      ind <= 1'b1;
    end
  endtask : aphase
  task automatic acc(input logic wr, input logic [7:0] a,
                     input logic [15:0] d, output logic [15:0] r);
    logic [15:0] lo, hi;
    if (sep)
    begin
      @(posedge clk);
      host_ad <= a;
      strobe(wr, d, r);
    end
    else
    begin
      aphase(a);
      strobe(wr, {8'h00, d[7:0]}, lo);
      aphase(8'(a + 8'h01));
      strobe(wr, {8'h00, d[15:8]}, hi);
      r = {hi[7:0], lo[7:0]};
    end
  endtask : acc
  task automatic wrchk(input logic [7:0] a, input logic [15:0] d,
                       input logic [15:0] exp);
    acc(1'b1, a, d, q);
    acc(1'b0, a, 16'h0000, q);
    chk(q, exp);
  endtask : wrchk
  task automatic dma(input logic [7:0] n, input logic h);
    @(posedge clk);
    {beats, hs, start} <= {n, h, 1'b1};
    @(posedge clk);
    start <= 1'b0;
    repeat (40) @(posedge clk);
  endtask : dma
  initial
  begin
    {rst, start, hs, beats, ale, ind} = '0;
    {host_sel_n, rd_n, wr_n, rw, ds_n} = 5'h1f;
    {host_ad, host_data} = '0;
    {sep, style, phase, p_sep, p_style, p_phase} = 6'h3f;
    n_errors = 0;
    compares = 0;
    boot(1'b1, 1'b1, 1'b1);
    acc(1'b0, REG_EP_ENABLE, WORD_ZERO, q);
    chk(q, EP_ENABLE_RST);
    acc(1'b0, REG_DMA_CFG, WORD_ZERO, q);
    chk(q, DMA_CFG_RST);
    acc(1'b0, REG_PORT_STAT, WORD_ZERO, q);
    chk(q, 16'h000f);
    {p_style, p_phase, p_sep} <= 3'h0;
    acc(1'b0, REG_PORT_STAT, WORD_ZERO, q);
    chk(q, 16'h000f);
    {p_style, p_phase, p_sep} <= 3'h7;
    wrchk(REG_EP_ENABLE, 16'h8004, 16'h8007);
    wrchk(8'h10, 16'h1234, WORD_ZERO);
    acc(1'b1, REG_EP_INDEX, 16'h0002, q);
    acc(1'b1, REG_BUF_LEN, 16'h0004, q);
    acc(1'b0, REG_CTRL_FUNC, WORD_ZERO, q);
    chk(q, 16'h0004);
    acc(1'b1, REG_DMA_EP, 16'h0002, q);
    acc(1'b1, REG_DMA_COUNT, 16'h0004, q);
    acc(1'b1, REG_DMA_CMD, 16'(KIND_GDMA), q);
    dma(8'h02, 1'b0);
    wrchk(REG_DMA_REASON, WORD_ZERO, 16'h0001);
    wrchk(REG_DMA_REASON, 16'h0003, WORD_ZERO);
    acc(1'b0, REG_CTRL_FUNC, WORD_ZERO, q);
    chk(q, WORD_ZERO);
    acc(1'b0, REG_DATA_PORT, WORD_ZERO, q);
    chk(q, 16'hc300);
    acc(1'b0, REG_DATA_PORT, WORD_ZERO, q);
    chk(q, 16'hc301);
    acc(1'b1, REG_BUF_LEN, 16'h0004, q);
    wrchk(REG_CTRL_FUNC, 16'h0001, WORD_ZERO);
    // Nonzero count so only role or kind can refuse the command
    acc(1'b1, REG_DMA_COUNT, 16'h0004, q);
    acc(1'b1, REG_DMA_HW, 16'h0001, q);
    acc(1'b1, REG_DMA_CMD, 16'h0080 | 16'(KIND_MDMA), q);
    wrchk(REG_DMA_REASON, 16'h0001, 16'h0002);
    acc(1'b1, REG_DMA_REASON, 16'h0002, q);
    foreach (bad_kinds[i])
    begin
      acc(1'b1, REG_DMA_CMD, 16'(bad_kinds[i]), q);
      wrchk(REG_DMA_REASON, 16'h0001, 16'h0002);
      acc(1'b1, REG_DMA_REASON, 16'h0002, q);
    end
    acc(1'b1, REG_DMA_HW, WORD_ZERO, q);
    acc(1'b1, REG_DMA_CFG, 16'h0003, q);
    acc(1'b1, REG_DMA_COUNT, 16'h0004, q);
    acc(1'b1, REG_DMA_CMD, 16'(KIND_GDMA), q);
    repeat (4) @(posedge clk);
    chk({15'h0000, req}, 16'h0001);
    dma(8'h02, 1'b1);
    wrchk(REG_DMA_REASON, WORD_ZERO, 16'h0001);
    boot(1'b1, 1'b0, 1'b1);
    acc(1'b0, REG_PORT_STAT, WORD_ZERO, q);
    chk(q, 16'h000d);
    wrchk(REG_EP_ENABLE, 16'h0010, 16'h0013);
    boot(1'b0, 1'b1, 1'b0);
    acc(1'b0, REG_PORT_STAT, WORD_ZERO, q);
    chk(q, 16'h000a);
    wrchk(REG_EP_ENABLE, 16'h0120, 16'h0123);
    acc(1'b1, REG_DMA_HW, 16'h0001, q);
    acc(1'b1, REG_DMA_COUNT, 16'h0004, q);
    base = pulses;
    acc(1'b1, REG_DMA_CMD, 16'h0080 | 16'(KIND_MDMA), q);
    repeat (40) @(posedge clk);
    chk(16'(pulses - base), 16'h0002);
    wrchk(REG_DMA_REASON, WORD_ZERO, 16'h0001);
    acc(1'b1, REG_DMA_CFG, WORD_ZERO, q);
    acc(1'b1, REG_DMA_COUNT, 16'h0003, q);
    base = pulses;
    acc(1'b1, REG_DMA_CMD, 16'h0080 | 16'(KIND_MDMA), q);
    repeat (40) @(posedge clk);
    chk(16'(pulses - base), 16'h0003);
    boot(1'b0, 1'b0, 1'b1);
    acc(1'b0, REG_PORT_STAT, WORD_ZERO, q);
    chk(q, 16'h000c);
    wrchk(REG_EP_ENABLE, 16'h4000, 16'h4003);
    tally_and_finish();
  end
  initial
  begin
    #3000000;
    n_errors++;
    tally_and_finish();
  end
endmodule : ubhp_port_tb_top
